// ==== hdl/pcr_config_regs.sv ====
`default_nettype none

// How it works
// - Manual bit set makes charge-pump current come from the three-bit code.
// - Lock detection runs only while the lock-detect enable bit is one.
// - Lock reported after error stays in window for 128, 256, 512 or 1024 cycles.
// - Lock condition reads back at bit 24 of address 0x00.
// - Auxiliary divider power-down zero enables sync output, one disables it.
// - Calibration clock runs only when both power-down bits are zero.
// - Writing one to the calibration start bit launches a converter calibration.
// - Ramp limit, step and rate values act only while ramp enable is one.
// - A 32-bit ramp lower limit lives at address 0x04.
// - A 32-bit ramp upper limit lives at address 0x05.
// - A 32-bit rising step size lives at address 0x06.
// - A 32-bit falling step size lives at address 0x07.
// - Upper 16 bits at 0x08 set the interval between decrement steps.
// - Lower 16 bits at 0x08 set the interval between increment steps.
// - Lock window counts cycles of the phase detector reference clock.
module pcr_config_regs
	import pcr_pkg::*;
(
	// Clock and reset
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	// Control port
	input  wire pcr_reg_req_t  regReq,
	output pcr_reg_rsp_t       regRsp,
	// PLL pins
	input  wire logic          refClkPin,
	input  wire logic          phaseInWindowPin,
	// PLL controls
	output pcr_cp_cfg_t        chargePump,
	output logic               pllLocked,
	// Clock gating and calibration
	output logic               syncOutEnable,
	output logic               dacCalClockEnable,
	output logic               dacCalStart,
	// Ramp sweep generator
	output pcr_ramp_cfg_t      rampCfg
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        rampEnable;
		logic        cpManual;
		logic [2:0]  cpCode;
		logic        lockDetEn;
		logic [1:0]  lockWinSel;
		logic        auxDivPd;
		logic        calClkPd;
		logic        calStart;
		logic [23:0] calFill;
		logic [31:0] rampLower;
		logic [31:0] rampUpper;
		logic [31:0] riseStep;
		logic [31:0] fallStep;
		logic [31:0] slopeRate;
		logic        rdValid;
		logic [31:0] rdData;
		pcr_cp_cfg_t   cpOut;
		pcr_ramp_cfg_t rampOut;
	} pcr_regs_state_t;

	pcr_regs_state_t stateReg;
	pcr_regs_state_t stateNext;

	logic        lockNow;
	logic [31:0] readWord;
	logic        wrSecond;
	logic        wrLoop;
	logic        wrCal;

	// ----------------------------------------------------------------
	// Lock detection
	// ----------------------------------------------------------------
	pcr_lock_detect uLockDetect
	(
		.clk_sys          (clk_sys),
		.rst_n            (rst_n),
		.refClkPin        (refClkPin),
		.phaseInWindowPin (phaseInWindowPin),
		.detectEnable     (stateReg.lockDetEn),
		.windowSel        (stateReg.lockWinSel),
		.pllLocked        (lockNow)
	);

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	// Any bit not listed here is open and reads zero.
	always_comb
	begin
		readWord = '0;
		unique case (regReq.addr)
			PCR_ADDR_STATUS:
			begin
				readWord[PCR_STATUS_LOCK_BIT] = lockNow;
			end
			PCR_ADDR_SECOND_CTL:
			begin
				readWord[PCR_RAMP_ENABLE_BIT] = stateReg.rampEnable;
			end
			PCR_ADDR_PLL_LOOP:
			begin
				readWord[PCR_CP_MANUAL_BIT]                  = stateReg.cpManual;
				readWord[PCR_CP_CODE_MSB:PCR_CP_CODE_LSB]    = stateReg.cpCode;
				readWord[PCR_LOCK_DET_EN_BIT]                = stateReg.lockDetEn;
				readWord[PCR_LOCK_WIN_MSB:PCR_LOCK_WIN_LSB]  = stateReg.lockWinSel;
			end
			PCR_ADDR_CAL_CTL:
			begin
				// Start bit is a trigger and always reads back as zero
				readWord[PCR_AUX_DIV_PD_BIT]  = stateReg.auxDivPd;
				readWord[PCR_CAL_CLK_PD_BIT]  = stateReg.calClkPd;
				readWord[PCR_CAL_FILL_MSB:0]  = stateReg.calFill;
			end
			PCR_ADDR_RAMP_LO:    readWord = stateReg.rampLower;
			PCR_ADDR_RAMP_HI:    readWord = stateReg.rampUpper;
			PCR_ADDR_RISE_STEP:  readWord = stateReg.riseStep;
			PCR_ADDR_FALL_STEP:  readWord = stateReg.fallStep;
			PCR_ADDR_SLOPE_RATE: readWord = stateReg.slopeRate;
			default:             readWord = '0;
		endcase
	end

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	assign wrSecond = regReq.wrEn && (regReq.addr == PCR_ADDR_SECOND_CTL);
	assign wrLoop   = regReq.wrEn && (regReq.addr == PCR_ADDR_PLL_LOOP);
	assign wrCal    = regReq.wrEn && (regReq.addr == PCR_ADDR_CAL_CTL);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		stateNext = stateReg;

		// Read answer, registered so data leaves from flops
		stateNext.rdValid = regReq.rdEn && !regReq.wrEn;
		if (regReq.rdEn && !regReq.wrEn)
			stateNext.rdData = readWord;

		// Calibration start is a one-cycle pulse
		stateNext.calStart = 1'b0;

		if (wrSecond)
			stateNext.rampEnable = regReq.wrData[PCR_RAMP_ENABLE_BIT];

		if (wrLoop)
		begin
			stateNext.cpManual   = regReq.wrData[PCR_CP_MANUAL_BIT];
			stateNext.cpCode     = regReq.wrData[PCR_CP_CODE_MSB:PCR_CP_CODE_LSB];
			stateNext.lockDetEn  = regReq.wrData[PCR_LOCK_DET_EN_BIT];
			stateNext.lockWinSel = regReq.wrData[PCR_LOCK_WIN_MSB:PCR_LOCK_WIN_LSB];
		end

		if (wrCal)
		begin
			stateNext.auxDivPd = regReq.wrData[PCR_AUX_DIV_PD_BIT];
			stateNext.calClkPd = regReq.wrData[PCR_CAL_CLK_PD_BIT];
			stateNext.calFill  = regReq.wrData[PCR_CAL_FILL_MSB:0];
			stateNext.calStart = regReq.wrData[PCR_CAL_START_BIT];
		end

		if (regReq.wrEn)
		begin
			unique case (regReq.addr)
				PCR_ADDR_RAMP_LO:    stateNext.rampLower = regReq.wrData;
				PCR_ADDR_RAMP_HI:    stateNext.rampUpper = regReq.wrData;
				PCR_ADDR_RISE_STEP:  stateNext.riseStep  = regReq.wrData;
				PCR_ADDR_FALL_STEP:  stateNext.fallStep  = regReq.wrData;
				PCR_ADDR_SLOPE_RATE: stateNext.slopeRate = regReq.wrData;
				default:             ;
			endcase
		end

		// Charge-pump code only counts once the manual bit is set
		stateNext.cpOut.manual = stateNext.cpManual;
		stateNext.cpOut.code   = stateNext.cpManual ? stateNext.cpCode : '0;

		// Ramp values are held at zero while the sweep is disabled, so
		// a half-programmed set never leaks into the sweep engine.
		stateNext.rampOut = '0;
		stateNext.rampOut.enable = stateNext.rampEnable;
		if (stateNext.rampEnable)
		begin
			stateNext.rampOut.lowerLimit = stateNext.rampLower;
			stateNext.rampOut.upperLimit = stateNext.rampUpper;
			stateNext.rampOut.riseStep   = stateNext.riseStep;
			stateNext.rampOut.fallStep   = stateNext.fallStep;
			stateNext.rampOut.fallRate   = stateNext.slopeRate[PCR_RATE_NEG_MSB:PCR_RATE_NEG_LSB];
			stateNext.rampOut.riseRate   = stateNext.slopeRate[PCR_RATE_POS_MSB:0];
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stateReg           <= '0;
			stateReg.calFill   <= PCR_CAL_FILL_RESET;
			stateReg.rampLower <= PCR_RESET_WORD;
			stateReg.rampUpper <= PCR_RESET_WORD;
			stateReg.riseStep  <= PCR_RESET_WORD;
			stateReg.fallStep  <= PCR_RESET_WORD;
			stateReg.slopeRate <= PCR_RESET_WORD;
		end
		else
		begin
			stateReg <= stateNext;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign regRsp.rdValid    = stateReg.rdValid;
	assign regRsp.rdData     = stateReg.rdData;
	assign chargePump        = stateReg.cpOut;
	assign pllLocked         = lockNow;
	assign syncOutEnable     = !stateReg.auxDivPd;
	assign dacCalClockEnable = !stateReg.calClkPd && !stateReg.auxDivPd;
	assign dacCalStart       = stateReg.calStart;
	assign rampCfg           = stateReg.rampOut;

endmodule // pcr_config_regs

`default_nettype wire

// ==== hdl/pcr_lock_detect.sv ====
`default_nettype none

module pcr_lock_detect
	import pcr_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// Pins from the PLL
	input  wire logic       refClkPin,
	input  wire logic       phaseInWindowPin,
	// Configuration
	input  wire logic       detectEnable,
	input  wire logic [1:0] windowSel,
	// Status
	output logic            pllLocked
);

	typedef struct packed {
		logic [2:0]                refSync;
		logic [2:0]                winSync;
		logic                      refLvl;
		logic                      winLvl;
		logic [PCR_LOCK_CNT_W-1:0] count;
		logic                      locked;
	} pcr_lock_state_t;

	pcr_lock_state_t stateReg;
	pcr_lock_state_t stateNext;

	logic [PCR_LOCK_CNT_W-1:0] target;

	// ----------------------------------------------------------------
	// Window counter, advanced on each filtered reference rising edge
	// ----------------------------------------------------------------
	// The reference is oversampled, so it must stay well below a
	// quarter of the system clock rate for every edge to be seen.
	always_comb
	begin
		stateNext = stateReg;
		target    = pcrLockCycles(windowSel);
		stateNext.refSync = {stateReg.refSync[1:0], refClkPin};
		stateNext.winSync = {stateReg.winSync[1:0], phaseInWindowPin};
		if (stateReg.refSync[1] == stateReg.refSync[2])
			stateNext.refLvl = stateReg.refSync[2];
		if (stateReg.winSync[1] == stateReg.winSync[2])
			stateNext.winLvl = stateReg.winSync[2];
		if (!detectEnable)
		begin
			stateNext.count  = '0;
			stateNext.locked = 1'b0;
		end
		else if (stateNext.refLvl && !stateReg.refLvl)
		begin
			if (!stateReg.winLvl)
			begin
				stateNext.count  = '0;
				stateNext.locked = 1'b0;
			end
			else if (!stateReg.locked)
			begin
				if (stateReg.count == target - 11'h001)
					stateNext.locked = 1'b1;
				else
					stateNext.count = stateReg.count + 11'h001;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			stateReg <= '0;
		else
			stateReg <= stateNext;
	end

	assign pllLocked = stateReg.locked;

endmodule // pcr_lock_detect

`default_nettype wire

// ==== hdl/pcr_pkg.sv ====
`default_nettype none

package pcr_pkg;

	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] PCR_ADDR_STATUS     = 8'h00;
	localparam logic [7:0] PCR_ADDR_SECOND_CTL = 8'h01;
	localparam logic [7:0] PCR_ADDR_PLL_LOOP   = 8'h02;
	localparam logic [7:0] PCR_ADDR_CAL_CTL    = 8'h03;
	localparam logic [7:0] PCR_ADDR_RAMP_LO    = 8'h04;
	localparam logic [7:0] PCR_ADDR_RAMP_HI    = 8'h05;
	localparam logic [7:0] PCR_ADDR_RISE_STEP  = 8'h06;
	localparam logic [7:0] PCR_ADDR_FALL_STEP  = 8'h07;
	localparam logic [7:0] PCR_ADDR_SLOPE_RATE = 8'h08;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int PCR_STATUS_LOCK_BIT   = 24;
	localparam int PCR_RAMP_ENABLE_BIT   = 19;
	localparam int PCR_CP_MANUAL_BIT     = 6;
	localparam int PCR_CP_CODE_LSB       = 3;
	localparam int PCR_CP_CODE_MSB       = 5;
	localparam int PCR_LOCK_DET_EN_BIT   = 2;
	localparam int PCR_LOCK_WIN_LSB      = 0;
	localparam int PCR_LOCK_WIN_MSB      = 1;
	localparam int PCR_AUX_DIV_PD_BIT    = 26;
	localparam int PCR_CAL_CLK_PD_BIT    = 25;
	localparam int PCR_CAL_START_BIT     = 24;
	localparam int PCR_CAL_FILL_MSB      = 23;
	localparam int PCR_RATE_NEG_LSB      = 16;
	localparam int PCR_RATE_NEG_MSB      = 31;
	localparam int PCR_RATE_POS_MSB      = 15;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] PCR_RESET_WORD = 32'h0000_0000;
	localparam logic [23:0] PCR_CAL_FILL_RESET = 24'h00_0000;

	// ----------------------------------------------------------------
	// Lock window
	// ----------------------------------------------------------------
	localparam int         PCR_LOCK_CNT_W   = 11;
	localparam logic [10:0] PCR_LOCK_MIN_CYC = 11'h080;

	// Lock window length in reference cycles for a two-bit code
	function automatic logic [10:0] pcrLockCycles(input logic [1:0] code);
		pcrLockCycles = PCR_LOCK_MIN_CYC << code;
	endfunction

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        wrEn;
		logic        rdEn;
		logic [7:0]  addr;
		logic [31:0] wrData;
	} pcr_reg_req_t;

	typedef struct packed {
		logic        rdValid;
		logic [31:0] rdData;
	} pcr_reg_rsp_t;

	typedef struct packed {
		logic        enable;
		logic [31:0] lowerLimit;
		logic [31:0] upperLimit;
		logic [31:0] riseStep;
		logic [31:0] fallStep;
		logic [15:0] fallRate;
		logic [15:0] riseRate;
	} pcr_ramp_cfg_t;

	typedef struct packed {
		logic       manual;
		logic [2:0] code;
	} pcr_cp_cfg_t;

endpackage : pcr_pkg

`default_nettype wire

// ==== verification/pcr_config_regs_asserts.sv ====
`default_nettype none

module pcr_config_regs_chk
	import pcr_pkg::*;
(
	// Clock and reset
	input wire logic          clk_sys,
	input wire logic          rst_n,
	// Register port
	input wire pcr_reg_req_t  regReq,
	input wire pcr_reg_rsp_t  regRsp,
	// Pins and controls
	input wire logic          refClkPin,
	input wire logic          phaseInWindowPin,
	input wire pcr_cp_cfg_t   chargePump,
	input wire logic          pllLocked,
	input wire logic          syncOutEnable,
	input wire logic          dacCalClockEnable,
	input wire logic          dacCalStart,
	input wire pcr_ramp_cfg_t rampCfg
);
	timeunit 1ns;
	timeprecision 1ps;

	wire logic        calWr = regReq.wrEn && regReq.addr == PCR_ADDR_CAL_CTL;
	wire logic        pllWr = regReq.wrEn && regReq.addr == PCR_ADDR_PLL_LOOP;
	wire logic        rdGo  = regReq.rdEn && !regReq.wrEn;
	wire logic [31:0] wd    = regReq.wrData;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_cal_start: assert property (calWr && wd[24] |=> dacCalStart)
		else $error("cal start pulse missing");
	a_cal_quiet: assert property (!(calWr && wd[24]) |=> !dacCalStart)
		else $error("cal start without a written one");
	a_sync_out: assert property (calWr |=> syncOutEnable == !$past(wd[26]))
		else $error("sync output enable wrong");
	a_gate_hold: assert property (!calWr |=> $stable(syncOutEnable) && $stable(dacCalClockEnable))
		else $error("clock gating changed without a write");
	a_cal_clock: assert property (calWr |=> dacCalClockEnable == !($past(wd[25]) || $past(wd[26])))
		else $error("cal clock enable wrong");
	a_ramp_gated: assert property (!rampCfg.enable |-> rampCfg[159:0] == '0)
		else $error("ramp values leak while disabled");
	a_ramp_lower: assert property (regReq.wrEn && regReq.addr == PCR_ADDR_RAMP_LO
		|=> !rampCfg.enable || rampCfg.lowerLimit == $past(wd)) else $error("lower limit wrong");
	a_rate_split: assert property (regReq.wrEn && regReq.addr == PCR_ADDR_SLOPE_RATE
		|=> !rampCfg.enable || {rampCfg.fallRate, rampCfg.riseRate} == $past(wd)) else $error("rate wrong");
	a_cp_manual: assert property (pllWr
		|=> chargePump == ($past(wd[6]) ? {1'b1, $past(wd[5:3])} : 4'h0)) else $error("charge pump wrong");
	a_lock_read: assert property (rdGo && regReq.addr == PCR_ADDR_STATUS
		|=> regRsp.rdValid && regRsp.rdData == {7'h00, $past(pllLocked), 24'h000000}) else $error("status wrong");
endmodule // pcr_config_regs_chk

bind pcr_config_regs pcr_config_regs_chk pcr_config_regs_chk_inst (
	.clk_sys(clk_sys), .rst_n(rst_n), .regReq(regReq), .regRsp(regRsp),
	.refClkPin(refClkPin), .phaseInWindowPin(phaseInWindowPin), .chargePump(chargePump),
	.pllLocked(pllLocked), .syncOutEnable(syncOutEnable), .dacCalClockEnable(dacCalClockEnable),
	.dacCalStart(dacCalStart), .rampCfg(rampCfg)
);

`default_nettype wire

// ==== verification/tb.sv ====
`default_nettype none

module tb
	import pcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic          clk_sys = 1'b0;
	logic          rst_n;
	pcr_reg_req_t  regReq;
	pcr_reg_rsp_t  regRsp;
	logic          refClkPin;
	logic          phaseInWindowPin;
	pcr_cp_cfg_t   chargePump;
	logic          pllLocked;
	logic          syncOutEnable;
	logic          dacCalClockEnable;
	logic          dacCalStart;
	pcr_ramp_cfg_t rampCfg;
	logic [31:0]   expQ[$];
	logic [31:0]   lfsrReg = 32'h1467421f;
	logic [31:0]   val[5];
	logic [31:0]   d;
	int            nErrors = 0;
	int            numChecks = 0;

	always #4 clk_sys = ~clk_sys;

	pcr_config_regs pcr_config_regs_inst (
		.clk_sys(clk_sys), .rst_n(rst_n), .regReq(regReq), .regRsp(regRsp),
		.refClkPin(refClkPin), .phaseInWindowPin(phaseInWindowPin), .chargePump(chargePump),
		.pllLocked(pllLocked), .syncOutEnable(syncOutEnable), .dacCalClockEnable(dacCalClockEnable),
		.dacCalStart(dacCalStart), .rampCfg(rampCfg)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr();
		lfsrReg = {lfsrReg[30:0], lfsrReg[31] ^ lfsrReg[21] ^ lfsrReg[1] ^ lfsrReg[0]};
		return lfsrReg;
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		numChecks++;
		if (s !== e)
		begin
			nErrors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(negedge clk_sys);
		regReq = {1'b1, 1'b0, a, v};
		@(negedge clk_sys);
		regReq.wrEn = 1'b0;
	endtask

	// Expectation is queued before the strobe so the watcher never sees an answer first
	task automatic rd(input logic [7:0] a, input logic [31:0] v);
		@(negedge clk_sys);
		expQ.push_back(v);
		regReq = {1'b0, 1'b1, a, 32'h0};
		@(negedge clk_sys);
		regReq.rdEn = 1'b0;
	endtask

	// Four system cycles per half reference period keeps every edge visible past the synchronizer
	task automatic refPulses(input int n);
		repeat (n)
		begin
			repeat (4) @(negedge clk_sys);
			refClkPin = 1'b1;
			repeat (4) @(negedge clk_sys);
			refClkPin = 1'b0;
		end
		repeat (8) @(negedge clk_sys);
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", numChecks, nErrors);
		if (nErrors == 0 && numChecks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(negedge clk_sys)
	begin
		if (regRsp.rdValid === 1'b1)
		begin
			if (expQ.size() == 0)
				chk("rdValid", 32'h0, 32'h1);
			else
				chk("rdData", expQ.pop_front(), regRsp.rdData);
		end
	end

	initial
	begin
		#400_000;
		nErrors++;
		$display("MISMATCH watchdog expected done seen timeout");
		report_and_stop();
	end

	initial
	begin
		regReq = '0;
		refClkPin = 1'b0;
		phaseInWindowPin = 1'b0;
		rst_n = 1'b0;
		repeat (8) @(negedge clk_sys);
		rst_n = 1'b1;
		chk("syncOutEnable", 32'h1, {31'h0, syncOutEnable});
		chk("dacCalClockEnable", 32'h1, {31'h0, dacCalClockEnable});
		// Host duty: one calibration right after power-up, fill field at its defaults
		wr(PCR_ADDR_CAL_CTL, {8'h01, PCR_CAL_FILL_RESET});
		chk("dacCalStart", 32'h1, {31'h0, dacCalStart});
		for (int i = 0; i < 5; i++)
		begin
			val[i] = lfsr();
			wr(PCR_ADDR_RAMP_LO + 8'(i), val[i]);
			rd(PCR_ADDR_RAMP_LO + 8'(i), val[i]);
		end
		chk("rampOff", 32'h0, {31'h0, |rampCfg});
		wr(PCR_ADDR_SECOND_CTL, 32'hffff_ffff);
		rd(PCR_ADDR_SECOND_CTL, 32'h0008_0000);
		chk("rampLo", val[0], rampCfg.lowerLimit);
		chk("rampHi", val[1], rampCfg.upperLimit);
		chk("riseStep", val[2], rampCfg.riseStep);
		chk("fallStep", val[3], rampCfg.fallStep);
		chk("slopeRate", val[4], {rampCfg.fallRate, rampCfg.riseRate});
		rd(8'h0f, 32'h0);
		wr(PCR_ADDR_STATUS, 32'hffff_ffff);
		rd(PCR_ADDR_STATUS, 32'h0);
		for (int k = 0; k < 4; k++)
		begin
			d = lfsr();
			d[31:24] = {5'h1f, 2'(k), k[0]};
			d[23:0] = PCR_CAL_FILL_RESET;
			wr(PCR_ADDR_CAL_CTL, d);
			chk("dacCalStart", {31'h0, d[24]}, {31'h0, dacCalStart});
			chk("syncOutEnable", {31'h0, !d[26]}, {31'h0, syncOutEnable});
			chk("dacCalClockEnable", {31'h0, !(d[25] | d[26])}, {31'h0, dacCalClockEnable});
			@(negedge clk_sys);
			chk("dacCalStart", 32'h0, {31'h0, dacCalStart});
			rd(PCR_ADDR_CAL_CTL, {5'h0, d[26:25], 1'b0, d[23:0]});
		end
		for (int c = 0; c < 16; c++)
		begin
			wr(PCR_ADDR_PLL_LOOP, {25'h0, c[3], c[2:0], 3'h0});
			chk("chargePump", {28'h0, c[3], c[3] ? c[2:0] : 3'h0}, {28'h0, chargePump});
		end
		wr(PCR_ADDR_PLL_LOOP, 32'hffff_ffff);
		rd(PCR_ADDR_PLL_LOOP, 32'h0000_007f);
		for (int w = 0; w < 4; w++)
		begin
			wr(PCR_ADDR_PLL_LOOP, {29'h0, 1'b1, 2'(w)});
			phaseInWindowPin = 1'b1;
			refPulses((128 << w) - 1);
			chk("pllLocked", 32'h0, {31'h0, pllLocked});
			refPulses(1);
			chk("pllLocked", 32'h1, {31'h0, pllLocked});
			rd(PCR_ADDR_STATUS, 32'h0100_0000);
			wr(PCR_ADDR_PLL_LOOP, {30'h0, 2'(w)});
			refPulses(130);
			chk("pllLocked", 32'h0, {31'h0, pllLocked});
			phaseInWindowPin = 1'b0;
		end
		wr(PCR_ADDR_CAL_CTL, 32'h0);
		repeat (4) @(negedge clk_sys);
		chk("readsLeft", 32'h0, 32'(expQ.size()));
		report_and_stop();
	end
endmodule // tb

`default_nettype wire
